// File: sim/epfc_link_model.sv
// Purpose: Stand-in for the MAC receive and transmit engines
// Assumes: Frames are 60 bytes plus FCS, or 52 when cut short
// Notes: Idle data toggles every cycle
`timescale 1ns/1ns
`include "epfc_consts.vh"
module epfc_link_model
(
   input wire clock_in,
   input wire nrst_in,
   input wire send_in,
   input wire bad_in,
   input wire short_in,
   input wire [15:0] op_in,
   input wire [15:0] q_in,
   input wire stall_in,
   output reg [63:0] rx_data_out,
   output wire [7:0] rx_keep_out,
   output wire rx_valid_out,
   output wire rx_last_out,
   output wire rx_good_out,
   output reg tx_ready_out
);
   reg [3:0] beat_q;
   reg idle_q;
   assign rx_valid_out = beat_q != 4'h0;
   assign rx_last_out = beat_q == (short_in ? 4'h7 : 4'h8);
   assign rx_good_out = rx_last_out && !bad_in;
   assign rx_keep_out = rx_last_out ? 8'h0F : 8'hFF;
   always @*
   begin
      case (beat_q)
         4'h0: rx_data_out = {32{idle_q, !idle_q}};
         4'h1: rx_data_out = {16'h0000, `EPFC_PAUSE_MCAST};
         4'h2: rx_data_out = {op_in, `EPFC_CTRL_TYPE_LE, 32'h00000000};
         4'h3: rx_data_out = {48'h000000000000, q_in[7:0], q_in[15:8]};
         default: rx_data_out = 64'h0000000000000000;
      endcase
   end
   always @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         beat_q <= 4'h0;
         idle_q <= 1'b0;
         tx_ready_out <= 1'b1;
      end
      else
      begin
         idle_q <= !idle_q;
         tx_ready_out <= !stall_in || !tx_ready_out;
         if (rx_last_out)
            beat_q <= 4'h0;
         else if (beat_q != 4'h0 || send_in)
            beat_q <= beat_q + 4'h1;
      end
   end
endmodule

// File: sim/epfc_top_checker.sv
// Purpose: Port checks for the pause flow control block
// Assumes: One clock domain
// Notes: Bound into the top module
`timescale 1ns/1ns
`include "epfc_consts.vh"
module epfc_top_checker
(
   input wire clock_in,
   input wire nrst_in,
   input wire hreadyout_out,
   input wire hresp_out,
   input wire [63:0] rx_mac_data_in,
   input wire [7:0] rx_mac_keep_in,
   input wire [7:0] rx_client_keep_out,
   input wire rx_mac_valid_in,
   input wire rx_mac_last_in,
   input wire rx_mac_good_in,
   input wire [63:0] rx_client_data_out,
   input wire rx_client_valid_out,
   input wire rx_client_last_out,
   input wire rx_client_user_out,
   input wire rx_stat_good_out,
   input wire [63:0] tx_mac_data_out,
   input wire [7:0] tx_mac_keep_out,
   input wire tx_mac_valid_out,
   input wire tx_mac_last_out,
   input wire tx_mac_ready_in
);
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!nrst_in);
   sequence s_rx_end;
      rx_mac_valid_in && rx_mac_last_in;
   endsequence
   sequence s_pause_head;
      tx_mac_valid_out && tx_mac_data_out[47:0] == `EPFC_PAUSE_MCAST;
   endsequence
   a_bus_okay: assert property (hreadyout_out && !hresp_out)
      else $error("bus not ready or not okay");
   a_rx_copy: assert property (rx_mac_valid_in |=>
      rx_client_valid_out && rx_client_data_out == $past(rx_mac_data_in)
      && rx_client_keep_out == $past(rx_mac_keep_in))
      else $error("receive beat not copied");
   a_rx_end: assert property (s_rx_end |=> rx_client_last_out)
      else $error("last beat lost");
   a_bad_drop: assert property (s_rx_end and !rx_mac_good_in |=>
      !rx_client_user_out && !rx_stat_good_out)
      else $error("bad frame marked good");
   a_user_last: assert property (rx_client_user_out |-> rx_client_last_out)
      else $error("good mark off last beat");
   a_stat_good: assert property (rx_stat_good_out |->
      $past(rx_mac_good_in) && rx_client_last_out)
      else $error("statistic pulse without good frame");
   a_tx_hold: assert property (tx_mac_valid_out && !tx_mac_ready_in |=>
      tx_mac_valid_out && $stable(tx_mac_data_out))
      else $error("transmit beat changed while stalled");
   a_pause_end: assert property (s_pause_head |-> ##[1:40]
      (tx_mac_valid_out && tx_mac_last_out && tx_mac_keep_out == `EPFC_PAUSE_LAST_KEEP))
      else $error("pause frame did not end");
endmodule
bind epfc_top epfc_top_checker i_epfc_top_checker (.clock_in(clock_in), .nrst_in(nrst_in),
   .hreadyout_out(hreadyout_out), .hresp_out(hresp_out), .rx_mac_data_in(rx_mac_data_in),
   .rx_mac_keep_in(rx_mac_keep_in), .rx_client_keep_out(rx_client_keep_out),
   .rx_mac_valid_in(rx_mac_valid_in), .rx_mac_last_in(rx_mac_last_in),
   .rx_mac_good_in(rx_mac_good_in), .rx_client_data_out(rx_client_data_out),
   .rx_client_valid_out(rx_client_valid_out), .rx_client_last_out(rx_client_last_out),
   .rx_client_user_out(rx_client_user_out), .rx_stat_good_out(rx_stat_good_out),
   .tx_mac_data_out(tx_mac_data_out), .tx_mac_keep_out(tx_mac_keep_out),
   .tx_mac_valid_out(tx_mac_valid_out), .tx_mac_last_out(tx_mac_last_out),
   .tx_mac_ready_in(tx_mac_ready_in));

// File: sim/tb_top.sv
// Purpose: Self-checking bench for the pause flow control block
// Assumes: Bus answers with no wait states
// Notes: A quantum is 2.56 clock cycles
`timescale 1ns/1ns
`include "epfc_consts.vh"
module tb_top;
   localparam [47:0] SA = 48'h665544332211;
   localparam [15:0] POP = `EPFC_PAUSE_OP_LE;
   reg clk;
   reg nrst = 1'b0, hsel = 1'b0, hwrite = 1'b0, preq = 1'b0, cval = 1'b0, clast = 1'b0;
   reg send = 1'b0, bad = 1'b0, stall = 1'b0, shrt = 1'b0;
   reg [7:0] haddr = 8'h00, ckeep = 8'hFF;
   reg [1:0] htrans = 2'b00;
   reg [2:0] hsize = 3'b010;
   reg [31:0] hwdata = 32'h00000000, r;
   reg [15:0] pq = 16'h0000, op = 16'h0000, rq = 16'h0000;
   reg [63:0] cdata = 64'h0000000000000000;
   reg [63:0] txq[$];
   reg [1:0] rxend = 2'b10;
   wire hready, hresp, cready, mval, mlast, mready, rval, rlast, rgood, ucval, uclast, user, stat;
   wire [31:0] hrdata;
   wire [63:0] mdata, rdata;
   wire [7:0] mkeep, rkeep;
   integer fails = 0, checks = 0, n;
   epfc_top i_epfc_top (.clock_in(clk), .nrst_in(nrst), .hsel_in(hsel), .haddr_in(haddr),
      .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(hsize), .hwdata_in(hwdata),
      .hready_in(hready), .hreadyout_out(hready), .hresp_out(hresp), .hrdata_out(hrdata),
      .pause_req_valid_in(preq), .pause_req_data_in(pq), .tx_client_data_in(cdata),
      .tx_client_keep_in(ckeep), .tx_client_valid_in(cval), .tx_client_last_in(clast),
      .tx_client_ready_out(cready), .tx_mac_data_out(mdata), .tx_mac_keep_out(mkeep),
      .tx_mac_valid_out(mval), .tx_mac_last_out(mlast), .tx_mac_ready_in(mready),
      .rx_mac_data_in(rdata), .rx_mac_keep_in(rkeep), .rx_mac_valid_in(rval),
      .rx_mac_last_in(rlast), .rx_mac_good_in(rgood), .rx_client_data_out(),
      .rx_client_keep_out(), .rx_client_valid_out(ucval), .rx_client_last_out(uclast),
      .rx_client_user_out(user), .rx_stat_good_out(stat));
   epfc_link_model i_epfc_link_model (.clock_in(clk), .nrst_in(nrst), .send_in(send),
      .bad_in(bad), .short_in(shrt), .op_in(op), .q_in(rq), .stall_in(stall),
      .rx_data_out(rdata),
      .rx_keep_out(rkeep), .rx_valid_out(rval), .rx_last_out(rlast), .rx_good_out(rgood),
      .tx_ready_out(mready));
   initial
   begin
      clk = 1'b0;
      forever #10 clk = !clk;
   end
   always @(posedge clk)
   begin
      if (mval && mready)
         txq.push_back(mdata);
      if (ucval && uclast)
         rxend <= {user, stat};
   end
   task close_out;
   begin
      if (fails == 0 && checks > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   end
   endtask
   task chk(input [63:0] got, input [63:0] exp);
   begin
      checks = checks + 1;
      if (got !== exp)
      begin
         fails = fails + 1;
         $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
      end
   end
   endtask
   task ahb(input w, input [7:0] a, input [31:0] d, output [31:0] q);
   begin
      hsel <= 1'b1;
      htrans <= `EPFC_HTRANS_NONSEQ;
      haddr <= a;
      hwrite <= w;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      hsel <= 1'b0;
      htrans <= 2'b00;
      hwdata <= d;
      @(posedge clk);
      while (hready !== 1'b1) @(posedge clk);
      q = hrdata;
   end
   endtask
   task wr(input [7:0] a, input [31:0] d);
   begin
      ahb(1'b1, a, d, r);
   end
   endtask
   task rdc(input [7:0] a, input [31:0] e);
   begin
      ahb(1'b0, a, 32'h00000000, r);
      chk(r, e);
   end
   endtask
   task preqp(input [15:0] q);
   begin
      preq <= 1'b1;
      pq <= q;
      @(posedge clk);
      preq <= 1'b0;
   end
   endtask
   task cbeat(input [63:0] d, input l);
   begin
      cval <= 1'b1;
      cdata <= d;
      clast <= l;
      @(posedge clk);
      while (cready !== 1'b1) @(posedge clk);
   end
   endtask
   task waitq(input integer m);
      integer i;
   begin
      for (i = 0; i < 300 && txq.size() < m; i = i + 1)
         @(posedge clk);
      repeat (30) @(posedge clk);
      chk(txq.size(), m);
   end
   endtask
   task pchk(input integer b, input [15:0] q);
   begin
      chk(txq[b], {SA[15:0], `EPFC_PAUSE_MCAST});
      chk(txq[b + 1], {POP, `EPFC_CTRL_TYPE_LE, SA[47:16]});
      chk(txq[b + 2], {48'h000000000000, q[7:0], q[15:8]});
   end
   endtask
   task rxf(input [15:0] o, input [15:0] q, input b);
   begin
      op <= o;
      rq <= q;
      bad <= b;
      send <= 1'b1;
      @(posedge clk);
      send <= 1'b0;
      repeat (10) @(posedge clk);
   end
   endtask
   task wready;
   begin
      n = 0;
      while (cready !== 1'b1 && n < 400)
      begin
         @(posedge clk);
         n = n + 1;
      end
   end
   endtask
   initial
   begin
      #100000;
      fails = fails + 1;
      close_out;
   end
   initial
   begin
      repeat (10) @(posedge clk);
      nrst <= 1'b1;
      @(posedge clk);
      rdc(`EPFC_REG_CTRL, 32'h00000000);
      rdc(8'h40, 32'h00000000);
      wr(`EPFC_REG_ADDR_LO, 32'h44332211);
      wr(`EPFC_REG_ADDR_HI, 32'h00006655);
      rdc(`EPFC_REG_ADDR_HI, 32'h00006655);
      preqp(16'h1234);
      waitq(0);
      wr(`EPFC_REG_CTRL, 32'h00000001);
      preqp(16'hA55A);
      waitq(8);
      pchk(0, 16'hA55A);
      stall <= 1'b1;
      cbeat(64'h1111111111111111, 1'b0);
      cval <= 1'b0;
      while (txq.size() < 9) @(posedge clk);
      preq <= 1'b1;
      pq <= 16'h0011;
      @(posedge clk);
      pq <= 16'h0022;
      @(posedge clk);
      preq <= 1'b0;
      cbeat(64'h2222222222222222, 1'b1);
      cval <= 1'b0;
      waitq(18);
      chk(txq[9], 64'h2222222222222222);
      pchk(10, 16'h0022);
      stall <= 1'b0;
      wr(`EPFC_REG_CTRL, 32'h00000003);
      rxf(POP, 16'h0200, 1'b1);
      chk(rxend, 2'b00);
      chk(cready, 1'b1);
      rxf(POP, 16'h0200, 1'b0);
      chk(rxend, 2'b01);
      ahb(1'b0, `EPFC_REG_STATUS, 32'h00000000, r);
      chk(r[0], 1'b1);
      chk(cready, 1'b0);
      preqp(16'h0033);
      waitq(26);
      pchk(18, 16'h0033);
      rxf(POP, 16'h0000, 1'b0);
      wready;
      chk(n < 5, 1'b1);
      rxf(POP, 16'd40, 1'b0);
      wready;
      chk(n > 95 && n < 107, 1'b1);
      rxf(16'h0200, 16'h0100, 1'b0);
      chk(rxend, 2'b11);
      chk(cready, 1'b1);
      shrt <= 1'b1;
      rxf(POP, 16'h0100, 1'b0);
      chk(rxend, 2'b00);
      chk(cready, 1'b1);
      wr(`EPFC_REG_CTRL, 32'h00000007);
      rxf(POP, 16'h0000, 1'b0);
      chk(rxend, 2'b01);
      shrt <= 1'b0;
      wr(`EPFC_REG_CTRL, 32'h00000001);
      rxf(POP, 16'h0100, 1'b0);
      chk(rxend, 2'b11);
      chk(cready, 1'b1);
      wr(`EPFC_REG_REFRESH, 32'h00000010);
      wr(`EPFC_REG_CTRL, 32'h00000019);
      preq <= 1'b1;
      pq <= 16'h0044;
      repeat (60) @(posedge clk);
      preq <= 1'b0;
      waitq(50);
      pchk(26, 16'h0044);
      pchk(34, 16'h0044);
      pchk(42, 16'h0000);
      close_out;
   end
endmodule

// File: src/epfc_consts.vh
// Purpose: Constants for the Ethernet pause flow control block
// Assumes: 64-bit client streams, byte 0 of a frame in bits [7:0]
// Notes: Times in picoseconds, cycle counts derived from them
`ifndef EPFC_CONSTS_VH
`define EPFC_CONSTS_VH

// Register byte offsets
`define EPFC_REG_CTRL 8'h00
`define EPFC_REG_ADDR_LO 8'h04
`define EPFC_REG_ADDR_HI 8'h08
`define EPFC_REG_REFRESH 8'h0C
`define EPFC_REG_STATUS 8'h10

// Control register fields
`define EPFC_CTRL_TX_EN 0
`define EPFC_CTRL_RX_EN 1
`define EPFC_CTRL_LEN_DIS 2
`define EPFC_CTRL_EXT 3
`define EPFC_CTRL_AUTO_RESUME 4
`define EPFC_CTRL_W 5
`define EPFC_CTRL_RST 5'h00

// Reset values
`define EPFC_ADDR_RST 48'h000000000000
`define EPFC_REFRESH_RST 16'h0000

// Frame constants, byte 0 in the low bits
`define EPFC_PAUSE_MCAST 48'h010000C28001
`define EPFC_CTRL_TYPE_LE 16'h0888
`define EPFC_PAUSE_OP_LE 16'h0100
`define EPFC_CTRL_FRAME_BYTES 16'd64
`define EPFC_FCS_BYTES 16'd4
`define EPFC_PAUSE_BEATS 3'd7
`define EPFC_PAUSE_LAST_KEEP 8'h0F

// Timing: one quantum is 512 bit times of 100 ps
`define EPFC_BIT_TIME_PS 100
`define EPFC_QUANTUM_BITS 512
`define EPFC_QUANTUM_PS (`EPFC_QUANTUM_BITS * `EPFC_BIT_TIME_PS)
`define EPFC_CLK_PERIOD_PS 20000

// AHB-Lite encodings
`define EPFC_HTRANS_NONSEQ 2'b10
`define EPFC_HTRANS_SEQ 2'b11

`endif

// File: src/epfc_quanta_timer.v
// Purpose: Down counter of pause quanta paced by line time
// Assumes: Clock period shorter than one quantum
// Notes: Fractional quantum kept in a picosecond accumulator
`timescale 1ns/1ns
`include "epfc_consts.vh"

module epfc_quanta_timer
(
   input wire clock_in,
   input wire nrst_in,
   input wire load_in,
   input wire [15:0] load_val_in,
   output wire [15:0] count_out,
   output wire zero_out
);

   localparam [31:0] STEP_FULL = `EPFC_CLK_PERIOD_PS;
   localparam [31:0] QUANTUM_FULL = `EPFC_QUANTUM_PS;
   localparam [16:0] STEP_PS = STEP_FULL[16:0];
   localparam [16:0] QUANTUM_PS = QUANTUM_FULL[16:0];

   reg [15:0] count_q;
   reg [15:0] count_d;
   reg [16:0] acc_q;
   reg [16:0] acc_d;
   reg [16:0] acc_sum;

   always @*
   begin
      acc_sum = acc_q + STEP_PS;
      count_d = count_q;
      acc_d = acc_q;
      if (load_in)
      begin
         // New value replaces what is left, fraction restarts
         count_d = load_val_in;
         acc_d = 17'h00000;
      end
      else if (count_q != 16'h0000)
      begin
         if (acc_sum >= QUANTUM_PS)
         begin
            // One quantum of line time has passed
            acc_d = acc_sum - QUANTUM_PS;
            count_d = count_q - 16'h0001;
         end
         else
         begin
            acc_d = acc_sum;
         end
      end
   end

   always @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         count_q <= 16'h0000;
         acc_q <= 17'h00000;
      end
      else
      begin
         count_q <= count_d;
         acc_q <= acc_d;
      end
   end

   assign count_out = count_q;
   assign zero_out = (count_q == 16'h0000);

endmodule

// File: src/epfc_top.v
// Purpose: Pause frame generation, pause decode and transmit inhibit
// Assumes: Streams carry no FCS; receive engine flags good frames on last
// Notes: Registers on AHB-Lite, zero wait states, always OKAY
//
// Chosen here: the AHB-Lite register port and the register addresses.
`timescale 1ns/1ns
`include "epfc_consts.vh"

module epfc_top
(
   input wire clock_in,
   input wire nrst_in,
   // AHB-Lite slave
   input wire hsel_in,
   input wire [7:0] haddr_in,
   input wire [1:0] htrans_in,
   input wire hwrite_in,
   input wire [2:0] hsize_in,
   input wire [31:0] hwdata_in,
   input wire hready_in,
   output reg hreadyout_out,
   output reg hresp_out,
   output reg [31:0] hrdata_out,
   // Pause request port
   input wire pause_req_valid_in,
   input wire [15:0] pause_req_data_in,
   // Client transmit stream
   input wire [63:0] tx_client_data_in,
   input wire [7:0] tx_client_keep_in,
   input wire tx_client_valid_in,
   input wire tx_client_last_in,
   output reg tx_client_ready_out,
   // Stream to transmit engine
   output reg [63:0] tx_mac_data_out,
   output reg [7:0] tx_mac_keep_out,
   output reg tx_mac_valid_out,
   output reg tx_mac_last_out,
   input wire tx_mac_ready_in,
   // Stream from receive engine
   input wire [63:0] rx_mac_data_in,
   input wire [7:0] rx_mac_keep_in,
   input wire rx_mac_valid_in,
   input wire rx_mac_last_in,
   input wire rx_mac_good_in,
   // Client receive stream
   output reg [63:0] rx_client_data_out,
   output reg [7:0] rx_client_keep_out,
   output reg rx_client_valid_out,
   output reg rx_client_last_out,
   output reg rx_client_user_out,
   output reg rx_stat_good_out
);

   localparam [1:0] TX_IDLE = 2'd0;
   localparam [1:0] TX_CLIENT = 2'd1;
   localparam [1:0] TX_PAUSE = 2'd2;

   // Configuration
   reg [`EPFC_CTRL_W-1:0] ctrl_q, ctrl_d;
   reg [47:0] addr_q, addr_d;
   reg [15:0] refresh_q, refresh_d;
   wire tx_en = ctrl_q[`EPFC_CTRL_TX_EN];
   wire rx_en = ctrl_q[`EPFC_CTRL_RX_EN];
   wire len_dis = ctrl_q[`EPFC_CTRL_LEN_DIS];
   wire ext_mode = ctrl_q[`EPFC_CTRL_EXT];
   wire auto_resume = ctrl_q[`EPFC_CTRL_AUTO_RESUME];

   // AHB data phase state
   reg wr_pend_q;
   reg [7:0] wr_addr_q;

   // Request and transmit state
   reg req_prev_q, held_q;
   reg pend_q, pend_d;
   reg [15:0] pend_val_q, pend_val_d;
   reg [15:0] held_val_q;
   reg [15:0] frame_val_q;
   reg [1:0] tx_state_q, tx_state_d;
   reg [2:0] beat_q;
   reg sof_q;
   reg cb_valid_q;
   reg [63:0] cb_data_q;
   reg [7:0] cb_keep_q;
   reg cb_last_q;

   // Receive decode state
   reg [1:0] rx_beat_q;
   reg [15:0] rx_bytes_q;
   reg da_ok_q, ctl_ok_q, op_ok_q;
   reg [15:0] rx_quanta_q;

   wire [15:0] inhibit_count;
   wire inhibit_done;
   wire refresh_zero;
   wire rx_load;
   wire refresh_load;

   // Pause frame beat builder
   function [63:0] pause_beat;
      input [2:0] idx;
      input [47:0] sa;
      input [15:0] q;
      begin
         case (idx)
            3'd0: pause_beat = {sa[15:0], `EPFC_PAUSE_MCAST};
            3'd1: pause_beat = {`EPFC_PAUSE_OP_LE, `EPFC_CTRL_TYPE_LE, sa[47:16]};
            3'd2: pause_beat = {48'h000000000000, q[7:0], q[15:8]};
            default: pause_beat = 64'h0000000000000000;
         endcase
      end
   endfunction

   // Byte count of one beat
   function [3:0] keep_bytes;
      input [7:0] keep;
      integer i;
      begin
         keep_bytes = 4'h0;
         for (i = 0; i < 8; i = i + 1)
         begin
            keep_bytes = keep_bytes + {3'b000, keep[i]};
         end
      end
   endfunction

   // AHB-Lite register access
   wire ahb_go = hsel_in && hready_in && htrans_in[1];
   reg [31:0] rd_mux;

   always @*
   begin
      ctrl_d = ctrl_q;
      addr_d = addr_q;
      refresh_d = refresh_q;
      if (wr_pend_q)
      begin
         case (wr_addr_q)
            `EPFC_REG_CTRL: ctrl_d = hwdata_in[`EPFC_CTRL_W-1:0];
            `EPFC_REG_ADDR_LO: addr_d[31:0] = hwdata_in;
            `EPFC_REG_ADDR_HI: addr_d[47:32] = hwdata_in[15:0];
            `EPFC_REG_REFRESH: refresh_d = hwdata_in[15:0];
            default: ctrl_d = ctrl_q;
         endcase
      end
      // Read sees a write finishing in the same cycle
      case (haddr_in)
         `EPFC_REG_CTRL: rd_mux = {{(32-`EPFC_CTRL_W){1'b0}}, ctrl_d};
         `EPFC_REG_ADDR_LO: rd_mux = addr_d[31:0];
         `EPFC_REG_ADDR_HI: rd_mux = {16'h0000, addr_d[47:32]};
         `EPFC_REG_REFRESH: rd_mux = {16'h0000, refresh_d};
         `EPFC_REG_STATUS: rd_mux = {inhibit_count, 14'h0000, pend_q, !inhibit_done};
         default: rd_mux = 32'h00000000;
      endcase
   end

   always @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         ctrl_q <= `EPFC_CTRL_RST;
         addr_q <= `EPFC_ADDR_RST;
         refresh_q <= `EPFC_REFRESH_RST;
         wr_pend_q <= 1'b0;
         wr_addr_q <= 8'h00;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         hrdata_out <= 32'h00000000;
      end
      else
      begin
         ctrl_q <= ctrl_d;
         addr_q <= addr_d;
         refresh_q <= refresh_d;
         wr_pend_q <= ahb_go && hwrite_in && (hsize_in == 3'b010);
         wr_addr_q <= haddr_in;
         hreadyout_out <= 1'b1;
         hresp_out <= 1'b0;
         if (ahb_go && !hwrite_in)
         begin
            hrdata_out <= rd_mux;
         end
      end
   end

   // Pause request capture
   wire req_rise = pause_req_valid_in && !req_prev_q;
   wire req_fall = !pause_req_valid_in && req_prev_q;
   wire tx_start_pause = (tx_state_q == TX_IDLE) && pend_q;
   reg new_req;
   reg [15:0] new_val;

   always @*
   begin
      new_req = 1'b0;
      new_val = pause_req_data_in;
      if (tx_en)
      begin
         if (!ext_mode)
         begin
            new_req = pause_req_valid_in;
         end
         else if (req_rise)
         begin
            new_req = 1'b1;
         end
         else if (held_q && refresh_zero && !pend_q && !tx_start_pause
                  && (tx_state_q != TX_PAUSE))
         begin
            new_req = 1'b1;
            new_val = held_val_q;
         end
         else if (req_fall && auto_resume)
         begin
            new_req = 1'b1;
            new_val = 16'h0000;
         end
      end
      // A new request wins over the start that empties the slot
      pend_d = new_req ? 1'b1 : (tx_start_pause ? 1'b0 : pend_q);
      pend_val_d = new_req ? new_val : pend_val_q;
   end

   assign refresh_load = tx_start_pause;

   // Transmit sequencing
   wire out_free = !tx_mac_valid_out || tx_mac_ready_in;
   wire cb_take = out_free && cb_valid_q && (tx_state_q == TX_CLIENT);
   wire cb_fill = tx_client_valid_in && tx_client_ready_out;
   wire cb_valid_next = cb_fill || (cb_valid_q && !cb_take);

   always @*
   begin
      tx_state_d = tx_state_q;
      case (tx_state_q)
         TX_IDLE:
         begin
            if (pend_q)
            begin
               tx_state_d = TX_PAUSE;
            end
            else if (cb_valid_q)
            begin
               tx_state_d = TX_CLIENT;
            end
         end
         TX_CLIENT:
         begin
            if (cb_take && cb_last_q)
            begin
               tx_state_d = TX_IDLE;
            end
         end
         TX_PAUSE:
         begin
            if (out_free && (beat_q == `EPFC_PAUSE_BEATS))
            begin
               tx_state_d = TX_IDLE;
            end
         end
         default: tx_state_d = TX_IDLE;
      endcase
   end

   always @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         req_prev_q <= 1'b0;
         held_q <= 1'b0;
         held_val_q <= 16'h0000;
         pend_q <= 1'b0;
         pend_val_q <= 16'h0000;
         frame_val_q <= 16'h0000;
         tx_state_q <= TX_IDLE;
         beat_q <= 3'd0;
         sof_q <= 1'b1;
         cb_valid_q <= 1'b0;
         cb_data_q <= 64'h0000000000000000;
         cb_keep_q <= 8'h00;
         cb_last_q <= 1'b0;
         tx_client_ready_out <= 1'b0;
         tx_mac_data_out <= 64'h0000000000000000;
         tx_mac_keep_out <= 8'h00;
         tx_mac_valid_out <= 1'b0;
         tx_mac_last_out <= 1'b0;
      end
      else
      begin
         req_prev_q <= pause_req_valid_in;
         held_q <= pause_req_valid_in && req_prev_q;
         if (req_rise)
         begin
            held_val_q <= pause_req_data_in;
         end
         pend_q <= pend_d;
         pend_val_q <= pend_val_d;
         tx_state_q <= tx_state_d;
         if (tx_start_pause)
         begin
            frame_val_q <= pend_val_q;
            beat_q <= 3'd0;
         end
         else if ((tx_state_q == TX_PAUSE) && out_free)
         begin
            beat_q <= beat_q + 3'd1;
         end
         // Holding slot for the client
         if (cb_fill)
         begin
            cb_valid_q <= 1'b1;
            cb_data_q <= tx_client_data_in;
            cb_keep_q <= tx_client_keep_in;
            cb_last_q <= tx_client_last_in;
            sof_q <= tx_client_last_in;
         end
         else if (cb_take)
         begin
            cb_valid_q <= 1'b0;
         end
         // No new frame may start while paused
         tx_client_ready_out <= !cb_valid_next
            && !(sof_q && !cb_fill && !inhibit_done)
            && !(cb_fill && tx_client_last_in && !inhibit_done);
         // Output register
         if (out_free)
         begin
            tx_mac_valid_out <= 1'b0;
            tx_mac_last_out <= 1'b0;
            if (tx_state_q == TX_PAUSE)
            begin
               tx_mac_valid_out <= 1'b1;
               tx_mac_data_out <= pause_beat(beat_q, addr_q, frame_val_q);
               tx_mac_keep_out <= (beat_q == `EPFC_PAUSE_BEATS)
                  ? `EPFC_PAUSE_LAST_KEEP : 8'hFF;
               tx_mac_last_out <= (beat_q == `EPFC_PAUSE_BEATS);
            end
            else if (cb_take)
            begin
               tx_mac_valid_out <= 1'b1;
               tx_mac_data_out <= cb_data_q;
               tx_mac_keep_out <= cb_keep_q;
               tx_mac_last_out <= cb_last_q;
            end
         end
      end
   end

   // Receive decode
   wire [15:0] rx_bytes_now = rx_bytes_q + {12'h000, keep_bytes(rx_mac_keep_in)};
   wire rx_is_ctl = ctl_ok_q || ((rx_beat_q == 2'd1)
      && (rx_mac_data_in[47:32] == `EPFC_CTRL_TYPE_LE));
   wire rx_len_ok = (rx_bytes_now + `EPFC_FCS_BYTES) == `EPFC_CTRL_FRAME_BYTES;
   wire rx_good = rx_mac_good_in && (!rx_is_ctl || rx_len_ok || len_dis);
   wire rx_match = da_ok_q && ctl_ok_q && op_ok_q;
   wire rx_act = rx_mac_valid_in && rx_mac_last_in && rx_en && rx_good && rx_match;

   assign rx_load = rx_act;

   always @(posedge clock_in or negedge nrst_in)
   begin
      if (!nrst_in)
      begin
         rx_beat_q <= 2'd0;
         rx_bytes_q <= 16'h0000;
         da_ok_q <= 1'b0;
         ctl_ok_q <= 1'b0;
         op_ok_q <= 1'b0;
         rx_quanta_q <= 16'h0000;
         rx_client_data_out <= 64'h0000000000000000;
         rx_client_keep_out <= 8'h00;
         rx_client_valid_out <= 1'b0;
         rx_client_last_out <= 1'b0;
         rx_client_user_out <= 1'b0;
         rx_stat_good_out <= 1'b0;
      end
      else
      begin
         rx_client_valid_out <= rx_mac_valid_in;
         rx_client_data_out <= rx_mac_data_in;
         rx_client_keep_out <= rx_mac_keep_in;
         rx_client_last_out <= rx_mac_valid_in && rx_mac_last_in;
         // Obeyed pause goes up marked not good
         rx_client_user_out <= rx_mac_valid_in && rx_mac_last_in
            && rx_good && !rx_act;
         rx_stat_good_out <= rx_mac_valid_in && rx_mac_last_in && rx_good;
         if (rx_mac_valid_in)
         begin
            if (rx_mac_last_in)
            begin
               rx_beat_q <= 2'd0;
               rx_bytes_q <= 16'h0000;
               da_ok_q <= 1'b0;
               ctl_ok_q <= 1'b0;
               op_ok_q <= 1'b0;
            end
            else
            begin
               rx_bytes_q <= rx_bytes_now;
               if (rx_beat_q != 2'd3)
               begin
                  rx_beat_q <= rx_beat_q + 2'd1;
               end
               if (rx_beat_q == 2'd0)
               begin
                  da_ok_q <= (rx_mac_data_in[47:0] == `EPFC_PAUSE_MCAST)
                     || (rx_mac_data_in[47:0] == addr_q);
               end
               if (rx_beat_q == 2'd1)
               begin
                  ctl_ok_q <= rx_mac_data_in[47:32] == `EPFC_CTRL_TYPE_LE;
                  op_ok_q <= rx_mac_data_in[63:48] == `EPFC_PAUSE_OP_LE;
               end
            end
            if (rx_beat_q == 2'd2)
            begin
               rx_quanta_q <= {rx_mac_data_in[7:0], rx_mac_data_in[15:8]};
            end
         end
      end
   end

   // Received pause time, counted down by line time
   epfc_quanta_timer u_inhibit
   (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .load_in(rx_load),
      .load_val_in(rx_quanta_q),
      .count_out(inhibit_count),
      .zero_out(inhibit_done)
   );

   // Quanta left until the last sent pause is refreshed
   epfc_quanta_timer u_refresh
   (
      .clock_in(clock_in),
      .nrst_in(nrst_in),
      .load_in(refresh_load),
      .load_val_in(refresh_q),
      .count_out(),
      .zero_out(refresh_zero)
   );

endmodule
